// ### tli_defines.svh
`ifndef TLI_DEFINES_SVH
`define TLI_DEFINES_SVH

// Source count and pending flag count (timer 2 high flag is the extra one).
`define TLI_NSRC         15
`define TLI_NFLAG        14
`define TLI_IDXW         4

// Register addresses.
`define TLI_ADDR_IE      8'hA8
`define TLI_ADDR_IP      8'hB8
`define TLI_ADDR_EIE     8'hE6
`define TLI_ADDR_EIP     8'hF6
`define TLI_ADDR_PENDL   8'hC0
`define TLI_ADDR_PENDH   8'hC1
`define TLI_ADDR_LINCTL  8'hC2
`define TLI_ADDR_STAT    8'hC3

// Reset values.
`define TLI_IE_RST       8'h00
`define TLI_IP_RST       7'h00
`define TLI_EIE_RST      8'h00
`define TLI_EIP_RST      8'h00
`define TLI_PEND_RST     14'h0000

// Field positions.
`define TLI_IE_GLOBAL    7
`define TLI_IP_UNUSED    1'b1
`define TLI_LIN_CLR_BIT  3
`define TLI_SRC_T2       5
`define TLI_SRC_LIN      12
`define TLI_SRC_DROP     13
`define TLI_SRC_MATCH    14
`define TLI_FLAG_T2H     13
`define TLI_PENDH_LIN    4
`define TLI_PENDH_T2H    5
`define TLI_N_AUTOCLR    4'h4

// Vector layout: base of the first source, spacing of 8 bytes.
`define TLI_VEC_BASE     16'h0003
`define TLI_VEC_SHIFT    3

`endif

// ### tli_pkg.sv
package tli_pkg;

  typedef enum logic [2:0] {
    TLI_IDLE  = 3'h0,
    TLI_CALL1 = 3'h1,
    TLI_CALL2 = 3'h3,
    TLI_CALL3 = 3'h2,
    TLI_CALL4 = 3'h6
  } tli_state_type;

endpackage : tli_pkg

// ### tli_arbiter.sv
`timescale 1ns/1ps
`include "tli_defines.svh"

module tli_arbiter
  import tli_pkg::*;
(
  input  wire logic [`TLI_NSRC-1:0] req_i,
  input  wire logic [`TLI_NSRC-1:0] high_i,
  output logic                      valid_o,
  output logic [`TLI_IDXW-1:0]      idx_o,
  output logic                      high_o
);

  logic [`TLI_NSRC-1:0] hi_req;
  logic [`TLI_NSRC-1:0] pick;

  // High level wins; within a level the lowest order number wins.
  always_comb begin
    hi_req  = req_i & high_i;
    high_o  = |hi_req;
    pick    = high_o ? hi_req : req_i;
    valid_o = |req_i;
    idx_o   = '0;
    for (int i = `TLI_NSRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx_o = `TLI_IDXW'(i);
      end
    end
  end

endmodule : tli_arbiter

// ### tli_handler.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "tli_defines.svh"

// Notes on behaviour
// - Fifteen sources, each with enable bit and priority bit; all but the live drop and match sources have a pending flag.
// - Software setting a pending flag requests exactly like hardware does.
// - Low level routines are preempted by high requests; high ones never.
// - Each source has its own priority bit, low after reset.
// - Simultaneous requests: high level is served before low level.
// - Equal level requests follow fixed order, external 0 first, port match last.
// - Vectors are 0x0003 plus 8 bytes per order step, up to 0x0073.
// - Pending requests are sampled and decoded every clock cycle.
// - Fastest response is one detect cycle plus four call cycles.
// - After a return instruction one more instruction runs before a call.
// - Worst response is 18 clocks: detect, return, divide, call.
// - A request waits while an equal or higher routine runs.
// - Global enable at bit 7 blocks all sources when zero.
// - Base enable bits 6 to 0 unmask the seven base sources.
// - Timer 2 enable unmasks both timer 2 overflow flags.
// - First four flags clear on vectoring; others need software clearing.
// - Flags set regardless of enables; a flag left set requests again.
// - Requests under global disable stay pending until enabled again.

module tli_handler
  import tli_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic [7:0]                addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [7:0]                rdata_o,
  input  wire logic [`TLI_NFLAG-1:0]     flag_set_i,
  input  wire logic                      drop_live_i,
  input  wire logic                      match_live_i,
  input  wire logic                      instr_end_i,
  input  wire logic                      reti_i,
  output logic                           req_pending_o,
  output logic                           lcall_o,
  output logic      [15:0]               vector_o,
  output logic                           serv_high_o,
  output logic                           serv_low_o
);

  logic [7:0]            ie_ff;
  logic [7:0]            nxt_ie;
  logic [6:0]            ip_ff;
  logic [6:0]            nxt_ip;
  logic [7:0]            eie_ff;
  logic [7:0]            nxt_eie;
  logic [7:0]            eip_ff;
  logic [7:0]            nxt_eip;
  logic [`TLI_NFLAG-1:0] pend_ff;
  logic [`TLI_NFLAG-1:0] nxt_pend;
  logic [7:0]            rdata_ff;
  logic [7:0]            nxt_rdata;
  tli_state_type         state_ff;
  tli_state_type         nxt_state;
  logic [15:0]           vec_ff;
  logic [15:0]           nxt_vec;
  logic                  lvl_ff;
  logic                  nxt_lvl;
  logic                  ins_hi_ff;
  logic                  nxt_ins_hi;
  logic                  ins_lo_ff;
  logic                  nxt_ins_lo;

  logic [`TLI_NSRC-1:0]  src;
  logic [`TLI_NSRC-1:0]  en_v;
  logic [`TLI_NSRC-1:0]  pri_v;
  logic [`TLI_NSRC-1:0]  req;
  logic [`TLI_NSRC-1:0]  elig;
  logic                  arb_valid;
  logic [`TLI_IDXW-1:0]  arb_idx;
  logic                  arb_high;
  logic                  accept;

  // Per-source request line built from pending flags or live conditions.
  for (genvar g = 0; g < `TLI_NSRC; g++) begin : g_src
    if (g == `TLI_SRC_T2) begin : g_t2
      assign src[g] = pend_ff[g] | pend_ff[`TLI_FLAG_T2H];
    end else if (g == `TLI_SRC_DROP) begin : g_drop
      assign src[g] = drop_live_i;
    end else if (g == `TLI_SRC_MATCH) begin : g_match
      assign src[g] = match_live_i;
    end else begin : g_flag
      assign src[g] = pend_ff[g];
    end
  end

  assign en_v  = {eie_ff, ie_ff[6:0]};
  assign pri_v = {eip_ff, ip_ff};
  assign req   = src & en_v & {`TLI_NSRC{ie_ff[`TLI_IE_GLOBAL]}};
  // A running high routine blocks all; a running low one blocks low.
  assign elig  = (req & pri_v & {`TLI_NSRC{~ins_hi_ff}})
               | (req & ~pri_v & {`TLI_NSRC{~(ins_hi_ff | ins_lo_ff)}});

  tli_arbiter u_arb (
    .req_i   (elig),
    .high_i  (pri_v),
    .valid_o (arb_valid),
    .idx_o   (arb_idx),
    .high_o  (arb_high)
  );

  // Decoded every cycle; a call starts at an instruction end that is no return.
  assign accept = (state_ff == TLI_IDLE) && arb_valid && instr_end_i && !reti_i;

  // Register file and pending flags.
  always_comb begin
    nxt_ie    = ie_ff;
    nxt_ip    = ip_ff;
    nxt_eie   = eie_ff;
    nxt_eip   = eip_ff;
    nxt_pend  = pend_ff;
    nxt_rdata = 8'h00;
    if (wr_i) begin
      case (addr_i)
        `TLI_ADDR_IE:     nxt_ie  = wdata_i;
        `TLI_ADDR_IP:     nxt_ip  = wdata_i[6:0];
        `TLI_ADDR_EIE:    nxt_eie = wdata_i;
        `TLI_ADDR_EIP:    nxt_eip = wdata_i;
        `TLI_ADDR_PENDL:  nxt_pend[7:0] = wdata_i;
        `TLI_ADDR_PENDH: begin
          nxt_pend[11:8] = wdata_i[3:0];
          nxt_pend[`TLI_SRC_LIN] = pend_ff[`TLI_SRC_LIN] | wdata_i[`TLI_PENDH_LIN];
          nxt_pend[`TLI_FLAG_T2H] = wdata_i[`TLI_PENDH_T2H];
        end
        `TLI_ADDR_LINCTL: begin
          if (wdata_i[`TLI_LIN_CLR_BIT]) begin
            nxt_pend[`TLI_SRC_LIN] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (accept && (arb_idx < `TLI_N_AUTOCLR)) begin
      nxt_pend[arb_idx] = 1'b0;
    end
    nxt_pend = nxt_pend | flag_set_i;
    if (rd_i) begin
      case (addr_i)
        `TLI_ADDR_IE:    nxt_rdata = ie_ff;
        `TLI_ADDR_IP:    nxt_rdata = {`TLI_IP_UNUSED, ip_ff};
        `TLI_ADDR_EIE:   nxt_rdata = eie_ff;
        `TLI_ADDR_EIP:   nxt_rdata = eip_ff;
        `TLI_ADDR_PENDL: nxt_rdata = pend_ff[7:0];
        `TLI_ADDR_PENDH: nxt_rdata = {2'h0, pend_ff[13:8]};
        `TLI_ADDR_STAT:  nxt_rdata = {5'h00, lcall_o, ins_hi_ff, ins_lo_ff};
        default:         nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ie_ff    <= `TLI_IE_RST;
      ip_ff    <= `TLI_IP_RST;
      eie_ff   <= `TLI_EIE_RST;
      eip_ff   <= `TLI_EIP_RST;
      pend_ff  <= `TLI_PEND_RST;
      rdata_ff <= 8'h00;
    end else begin
      ie_ff    <= nxt_ie;
      ip_ff    <= nxt_ip;
      eie_ff   <= nxt_eie;
      eip_ff   <= nxt_eip;
      pend_ff  <= nxt_pend;
      rdata_ff <= nxt_rdata;
    end
  end

  // Call sequencer and in-service levels.
  always_comb begin
    nxt_state  = state_ff;
    nxt_vec    = vec_ff;
    nxt_lvl    = lvl_ff;
    nxt_ins_hi = ins_hi_ff;
    nxt_ins_lo = ins_lo_ff;
    if (reti_i) begin
      if (ins_hi_ff) begin
        nxt_ins_hi = 1'b0;
      end else begin
        nxt_ins_lo = 1'b0;
      end
    end
    case (state_ff)
      TLI_IDLE: begin
        if (accept) begin
          nxt_state = TLI_CALL1;
          nxt_vec   = `TLI_VEC_BASE + (16'(arb_idx) << `TLI_VEC_SHIFT);
          nxt_lvl   = arb_high;
        end
      end
      TLI_CALL1: nxt_state = TLI_CALL2;
      TLI_CALL2: nxt_state = TLI_CALL3;
      TLI_CALL3: nxt_state = TLI_CALL4;
      TLI_CALL4: begin
        nxt_state = TLI_IDLE;
        if (lvl_ff) begin
          nxt_ins_hi = 1'b1;
        end else begin
          nxt_ins_lo = 1'b1;
        end
      end
      default: nxt_state = TLI_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_ff  <= TLI_IDLE;
      vec_ff    <= 16'h0000;
      lvl_ff    <= 1'b0;
      ins_hi_ff <= 1'b0;
      ins_lo_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      vec_ff    <= nxt_vec;
      lvl_ff    <= nxt_lvl;
      ins_hi_ff <= nxt_ins_hi;
      ins_lo_ff <= nxt_ins_lo;
    end
  end

  assign rdata_o       = rdata_ff;
  assign req_pending_o = arb_valid;
  assign lcall_o       = (state_ff != TLI_IDLE);
  assign vector_o      = vec_ff;
  assign serv_high_o   = ins_hi_ff;
  assign serv_low_o    = ins_lo_ff;

  // Checks.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_call_length: assert property (accept |=> lcall_o [*4] ##1 !lcall_o)
    else $error("Long call did not last four cycles.");

  a_vector_addr: assert property (
    accept |=> vector_o == `TLI_VEC_BASE + (16'($past(arb_idx)) << `TLI_VEC_SHIFT))
    else $error("Vector address does not match the winning source.");

  a_reti_gap: assert property (reti_i |=> !lcall_o)
    else $error("Call started at the end of a return instruction.");

  a_global_off: assert property (!ie_ff[`TLI_IE_GLOBAL] |-> !req_pending_o)
    else $error("Request raised while globally disabled.");

  a_high_first: assert property (accept && |(elig & pri_v) |-> pri_v[arb_idx])
    else $error("Low level request won over a high one.");

  a_fixed_order: assert property (
    accept |-> ((elig & (pri_v[arb_idx] ? pri_v : ~pri_v))
                & ((15'h0001 << arb_idx) - 15'h0001)) == 15'h0000)
    else $error("Lower order source was passed over.");

  a_high_no_preempt: assert property (serv_high_o |-> !accept)
    else $error("High level routine was preempted.");

  a_low_wait: assert property (serv_low_o && accept |-> arb_high)
    else $error("Low request served inside a low routine.");

  a_auto_clear: assert property (
    accept && arb_idx < `TLI_N_AUTOCLR && flag_set_i == '0
    |=> !pend_ff[$past(arb_idx)])
    else $error("Auto-clearing flag stayed set after vectoring.");

  a_flag_sets: assert property (
    |flag_set_i |=> (pend_ff & $past(flag_set_i)) == $past(flag_set_i))
    else $error("Hardware event did not set its pending flag.");

  a_pend_hold: assert property (
    !ie_ff[`TLI_IE_GLOBAL] && pend_ff[`TLI_SRC_T2] && !wr_i |=> pend_ff[`TLI_SRC_T2])
    else $error("Pending flag lost while globally disabled.");

  c_fast_call: cover property (accept ##1 lcall_o [*4] ##1 serv_low_o);
  c_preempt: cover property (serv_low_o && accept && arb_high);
  c_reti_then_call: cover property (reti_i && arb_valid ##[1:20] accept);
  c_match_call: cover property (accept && arb_idx == 4'hE);

endmodule : tli_handler

// ### tli_cpu_model.sv
`timescale 1ns/1ps

module tli_cpu_model (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic lcall_i,
  input  wire logic ret_i,
  input  wire logic slow_i,
  output logic      instr_end_o,
  output logic      reti_o
);
  logic [3:0] cnt_ff;
  logic       ret_ff;

  // No boundary while the long call runs; slow mode stretches each instruction to 8 cycles.
  assign instr_end_o = resetn_i && !lcall_i && (cnt_ff == 4'h0);
  assign reti_o      = instr_end_o && ret_ff;

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_ff <= 4'h0;
      ret_ff <= 1'b0;
    end else begin
      cnt_ff <= (lcall_i || cnt_ff == 4'h0) ? (slow_i ? 4'h7 : 4'h0) : cnt_ff - 4'h1;
      ret_ff <= ret_i || (ret_ff && !reti_o);
    end
  end
endmodule : tli_cpu_model

// ### tli_handler_tb.sv
`timescale 1ns/1ps
`include "tli_defines.svh"

module tli_handler_tb;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        ret_i = 1'b0;
  logic        slow_i = 1'b0;
  logic        drop_live_i = 1'b0;
  logic        match_live_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic [13:0] flag_set_i = 14'h0000;
  logic [7:0]  rdata_o;
  logic [15:0] vector_o;
  logic        instr_end_i, reti_i, req_pending_o, lcall_o, serv_high_o, serv_low_o;
  logic [14:0] pend;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n, lat;

  tli_handler u_tli_handler (.mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .flag_set_i, .drop_live_i, .match_live_i, .instr_end_i, .reti_i, .req_pending_o,
    .lcall_o, .vector_o, .serv_high_o, .serv_low_o);
  tli_cpu_model u_tli_cpu_model (.mclk_i, .resetn_i, .lcall_i(lcall_o), .ret_i, .slow_i,
    .instr_end_o(instr_end_i), .reti_o(reti_i));

  always #25 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task final_report();
    $display("counts: checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, e}, "read data");
  endtask : rd

  task flags(input logic [13:0] m);
    @(posedge mclk_i);
    flag_set_i <= m;
    @(posedge mclk_i);
    flag_set_i <= 14'h0000;
  endtask : flags

  task wait_call(input logic [15:0] v);
    n = 0;
    while (lcall_o !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    lat = n;
    chk(vector_o, v, "vector");
    n = 0;
    while (lcall_o === 1'b1 && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(16'(n), 16'h0004, "call length");
  endtask : wait_call

  task reti();
    @(posedge mclk_i);
    ret_i <= 1'b1;
    @(posedge mclk_i);
    ret_i <= 1'b0;
    #1;
    n = 0;
    while (reti_i !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    #1;
  endtask : reti

  task idle(input string m);
    repeat (20) begin
      @(posedge mclk_i);
      #1;
      chk({15'h0000, lcall_o}, 16'h0000, m);
    end
  endtask : idle

  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(`TLI_ADDR_IE, 8'h00);
    rd(`TLI_ADDR_IP, 8'h80);
    rd(`TLI_ADDR_EIE, 8'h00);
    rd(`TLI_ADDR_EIP, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");

    wr(`TLI_ADDR_IE, 8'h81);
    flags(14'h0001);
    wait_call(16'h0003);
    chk(16'(lat), 16'h0001, "detect latency");
    chk({15'h0000, serv_low_o}, 16'h0001, "low service");
    rd(`TLI_ADDR_STAT, 8'h01);
    rd(`TLI_ADDR_PENDL, 8'h00);
    reti();
    chk({15'h0000, serv_low_o}, 16'h0000, "service end");
    $display("test latency done");

    wr(`TLI_ADDR_IE, 8'h7F);
    wr(`TLI_ADDR_EIE, 8'hFF);
    wr(`TLI_ADDR_PENDL, 8'h10);
    flags(14'h1FEF);
    drop_live_i  <= 1'b1;
    match_live_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk({15'h0000, req_pending_o}, 16'h0000, "global off");
    wr(`TLI_ADDR_EIE, 8'h00);
    wr(`TLI_ADDR_IE, 8'h80);
    #1;
    chk({15'h0000, req_pending_o}, 16'h0000, "masks off");
    wr(`TLI_ADDR_IE, 8'h7F);
    wr(`TLI_ADDR_EIE, 8'hFF);
    wr(`TLI_ADDR_IE, 8'hFF);
    pend = 15'h7FFF;
    for (int i = 0; i < 15; i++) begin
      wait_call(16'h0003 + 16'(i * 8));
      pend[i] = 1'b0;
      if (i >= 4 && i < 8) wr(`TLI_ADDR_PENDL, pend[7:0]);
      if (i >= 8 && i < 13) wr(`TLI_ADDR_PENDH, {4'h0, pend[11:8]});
      if (i == 12) begin
        rd(`TLI_ADDR_PENDH, 8'h10);
        wr(`TLI_ADDR_LINCTL, 8'h08);
        rd(`TLI_ADDR_PENDH, 8'h00);
      end
      if (i == 13) @(posedge mclk_i) drop_live_i <= 1'b0;
      if (i == 14) @(posedge mclk_i) match_live_i <= 1'b0;
      rd(`TLI_ADDR_PENDL, pend[7:0]);
      reti();
    end
    $display("test order done");

    slow_i <= 1'b1;
    wr(`TLI_ADDR_IP, 8'h02);
    flags(14'h0003);
    wait_call(16'h000B);
    chk({15'h0000, serv_high_o}, 16'h0001, "high service");
    idle("high preempted");
    reti();
    wait_call(16'h0003);
    flags(14'h2000);
    idle("equal level call");
    flags(14'h0002);
    wait_call(16'h000B);
    reti();
    idle("low still busy");
    reti();
    wait_call(16'h002B);
    reti();
    wait_call(16'h002B);
    wr(`TLI_ADDR_PENDH, 8'h00);
    reti();
    idle("flags cleared");
    $display("test priority done");
    final_report();
  end
endmodule : tli_handler_tb
